/* rtl/mpps_pkg.sv */
// Purpose: shared constants and types for the multiphase pwm sequencer
// Assumes: 25 MHz aclk, 32-bit axi4-lite register port
// Notes: switching period is held in aclk cycles
package mpps_pkg;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int FSW_MIN_HZ = 80_000;
    localparam int FSW_MAX_HZ = 1_000_000;
    localparam int PERIOD_W = 9;
    localparam logic [PERIOD_W-1:0] PERIOD_MIN = PERIOD_W'(CLK_HZ / FSW_MAX_HZ);
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = PERIOD_W'(CLK_HZ / FSW_MIN_HZ);
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 9'h064;
    localparam int SS_TIME_US = 2000;
    localparam int SS_CYCLES = SS_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [3:0] STRAP_WAIT = 4'h8;
    localparam int NPH = 4;
    localparam logic [2:0] NPH_TWO = 3'h2;
    localparam logic [2:0] NPH_THREE = 3'h3;
    localparam logic [2:0] NPH_FOUR = 3'h4;
    // ==========================================================
    // register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_NPH_LSB = 4;
    localparam int ST_PG_BIT = 7;
    localparam int ST_PWM_LSB = 8;
    localparam int ST_EN_BIT = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // synchroniser bit positions
    localparam int SY_SUPPLY = 0;
    localparam int SY_EN = 1;
    localparam int SY_FSDIS = 2;
    localparam int SY_UV = 3;
    localparam int SY_OV = 4;
    localparam int SY_P3 = 5;
    localparam int SY_P4 = 6;
    localparam int SY_TRIP = 7;
    localparam int SY_W = 11;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_STRAP = 4'h2,
        ST_SOFT = 4'h4,
        ST_RUN = 4'h8
    } mpps_state_t;
endpackage

/* rtl/mpps_top.sv */
// Purpose: phase timing, strap sensing, gating and power good of a multiphase buck
// Assumes: analog comparators deliver levels; ramp_cross high while level above ramp
// Notes: registers over axi4-lite; the forced-off time ends with a current hold strobe
// Operation
// - with no strap, run four phases, all sequenced each cycle.
// - four phases: each falling edge a quarter cycle after the previous.
// - third output strapped high: two phases, second ends half cycle later.
// - only fourth output strapped high: three phases spaced one third.
// - cycle starts when termination clock drops phase one; cycle between those.
// - termination period is switching period, 80 kHz to 1 MHz.
// - after any fall, output stays low at least a quarter cycle.
// - after forced-off, output rises when compensation crosses ramp.
// - high output stays high until its next termination instant.
// - enable rise starts soft-start; enable fall disables.
// - frequency-set pin driven high disables the controller.
// - run above supply power-on threshold, shut down below falling one.
// - power good low when output under window or over limit.
// - each forced-off interval ends with one settled current sample.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module mpps_top #(
    parameter int ADDR_W = 4,
    parameter int SS_CYCLES = mpps_pkg::SS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic supply_above_por,
    input wire logic enable_above_threshold,
    input wire logic freq_set_disable_pin,
    input wire logic output_under_window,
    input wire logic output_over_window,
    input wire logic [3:0] ramp_cross,
    output logic phase_one_out,
    output logic phase_two_out,
    input wire logic phase_three_in,
    output logic phase_three_out,
    output logic phase_three_oe,
    input wire logic phase_four_in,
    output logic phase_four_out,
    output logic phase_four_oe,
    output logic power_good_flag_out,
    output logic power_good_flag_oe,
    output logic [3:0] channel_current_sense_hold,
    output logic soft_start_active
);
    localparam int PW = mpps_pkg::PERIOD_W;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // elaboration checks
    if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr
        $error("ADDR_W out of range");
    end
    if (SS_CYCLES < 1 || SS_CYCLES >= (1 << 24)) begin : g_bad_ss
        $error("SS_CYCLES out of range");
    end

    // ==========================================================
    // input synchronisers
    logic [mpps_pkg::SY_W-1:0] sy_raw;
    logic [mpps_pkg::SY_W-1:0] sy1;
    logic [mpps_pkg::SY_W-1:0] sy2;
    logic [mpps_pkg::SY_W-1:0] sy3;
    logic [mpps_pkg::SY_W-1:0] filt;
    assign sy_raw = {ramp_cross, phase_four_in, phase_three_in, output_over_window,
                     output_under_window, freq_set_disable_pin, enable_above_threshold,
                     supply_above_por};

    // change accepted only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
            filt <= '0;
        end else begin
            sy1 <= sy_raw;
            sy2 <= sy1;
            sy3 <= sy2;
            filt <= (sy2 & sy3) | (filt & (sy2 ^ sy3));
        end
    end

    logic [3:0] trip;
    assign trip = filt[mpps_pkg::SY_TRIP +: 4];

    // ==========================================================
    // registers
    logic ctrl_run;
    logic [PW-1:0] period_reg;
    logic go;
    assign go = ctrl_run && filt[mpps_pkg::SY_SUPPLY] && filt[mpps_pkg::SY_EN]
                && !filt[mpps_pkg::SY_FSDIS];

    // ==========================================================
    // sequencing state
    mpps_pkg::mpps_state_t state;
    logic [3:0] strap_cnt;
    logic [23:0] ss_cnt;
    logic [2:0] nphase;
    logic [2:0] next_nphase;
    logic switching;
    assign switching = (state == mpps_pkg::ST_SOFT) || (state == mpps_pkg::ST_RUN);

    // fourth strap is ignored once the third is high, so an open pin is harmless
    always_comb begin
        if (filt[mpps_pkg::SY_P3]) begin
            next_nphase = mpps_pkg::NPH_TWO;
        end else if (filt[mpps_pkg::SY_P4]) begin
            next_nphase = mpps_pkg::NPH_THREE;
        end else begin
            next_nphase = mpps_pkg::NPH_FOUR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= mpps_pkg::ST_OFF;
            strap_cnt <= '0;
            ss_cnt <= '0;
        end else if (!go) begin
            state <= mpps_pkg::ST_OFF;
        end else begin
            case (state)
                mpps_pkg::ST_OFF: begin
                    state <= mpps_pkg::ST_STRAP;
                    strap_cnt <= mpps_pkg::STRAP_WAIT;
                end
                mpps_pkg::ST_STRAP: begin
                    // wait lets synchronisers see straps with outputs released
                    if (strap_cnt == 4'h0) begin
                        state <= mpps_pkg::ST_SOFT;
                        ss_cnt <= 24'(SS_CYCLES - 1);
                    end else begin
                        strap_cnt <= strap_cnt - 4'h1;
                    end
                end
                mpps_pkg::ST_SOFT: begin
                    if (ss_cnt == 24'h000000) begin
                        state <= mpps_pkg::ST_RUN;
                    end else begin
                        ss_cnt <= ss_cnt - 24'h000001;
                    end
                end
                mpps_pkg::ST_RUN: begin
                    state <= mpps_pkg::ST_RUN;
                end
                default: begin
                    state <= mpps_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nphase <= mpps_pkg::NPH_FOUR;
        end else if (state == mpps_pkg::ST_STRAP && strap_cnt == 4'h0 && go) begin
            nphase <= next_nphase;
        end
    end

    // ==========================================================
    // cycle counter
    logic [PW-1:0] cyc;
    logic [PW-1:0] period_cur;
    logic [PW-1:0] period_clamp;
    logic [PW-1:0] quarter;

    always_comb begin
        if (period_reg < mpps_pkg::PERIOD_MIN) begin
            period_clamp = mpps_pkg::PERIOD_MIN;
        end else if (period_reg > mpps_pkg::PERIOD_MAX) begin
            period_clamp = mpps_pkg::PERIOD_MAX;
        end else begin
            period_clamp = period_reg;
        end
    end
    // least time, so the quarter rounds up
    assign quarter = PW'((PW+1)'(period_cur) + (PW+1)'(3) >> 2);

    // new period only taken at a cycle boundary, keeping spacing symmetric
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc <= '0;
            period_cur <= mpps_pkg::PERIOD_RESET;
        end else if (!switching) begin
            cyc <= '0;
            period_cur <= period_clamp;
        end else if (cyc == period_cur - PW'(1)) begin
            cyc <= '0;
            period_cur <= period_clamp;
        end else begin
            cyc <= cyc + PW'(1);
        end
    end

    // ==========================================================
    // per-phase pulse logic
    logic [3:0] pwm;
    logic [3:0] term;
    logic [3:0] active;
    logic [3:0] strobe;
    logic [PW-1:0] off_cnt [4];
    logic [PW-1:0] offs [4];

    for (genvar k = 0; k < mpps_pkg::NPH; k++) begin : g_ph
        logic [PW+1:0] prod;
        assign prod = (PW+2)'(k) * (PW+2)'(period_cur);
        always_comb begin
            case (nphase)
                mpps_pkg::NPH_TWO: offs[k] = PW'(prod >> 1);
                mpps_pkg::NPH_THREE: offs[k] = PW'(prod / (PW+2)'(3));
                default: offs[k] = PW'(prod >> 2);
            endcase
        end
        assign active[k] = 3'(k) < nphase;
        assign term[k] = switching && active[k] && (cyc == offs[k]);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pwm[k] <= 1'b0;
                off_cnt[k] <= '0;
                strobe[k] <= 1'b0;
            end else if (!switching || !active[k]) begin
                pwm[k] <= 1'b0;
                off_cnt[k] <= '0;
                strobe[k] <= 1'b0;
            end else begin
                strobe[k] <= (off_cnt[k] == PW'(1));
                if (term[k]) begin
                    pwm[k] <= 1'b0;
                    off_cnt[k] <= quarter;
                end else if (off_cnt[k] != '0) begin
                    off_cnt[k] <= off_cnt[k] - PW'(1);
                end else if (trip[k]) begin
                    pwm[k] <= 1'b1;
                end
            end
        end

        a_fall_at_term: assert property (term[k] |=> !pwm[k])
            else $error("phase did not fall at its termination");
        a_high_holds: assert property (pwm[k] && !term[k] && go |=> pwm[k])
            else $error("phase fell without termination");
        a_rise_gated: assert property ($rose(pwm[k]) |->
            $past(off_cnt[k]) == '0 && $past(trip[k]))
            else $error("phase rose inside forced-off or without trip");
        a_sample_low: assert property (strobe[k] |-> !pwm[k] && off_cnt[k] == '0)
            else $error("current hold outside forced-off end");
    end

    // ==========================================================
    // pin drivers
    logic [3:0] drv;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv <= 4'h3;
            phase_one_out <= 1'b0;
            phase_two_out <= 1'b0;
            phase_three_out <= 1'b0;
            phase_four_out <= 1'b0;
            channel_current_sense_hold <= 4'h0;
            soft_start_active <= 1'b0;
        end else begin
            // straps must float while they are sensed
            drv <= switching ? active : 4'h3;
            phase_one_out <= pwm[0];
            phase_two_out <= pwm[1];
            phase_three_out <= pwm[2];
            phase_four_out <= pwm[3];
            channel_current_sense_hold <= strobe;
            soft_start_active <= (state == mpps_pkg::ST_SOFT);
        end
    end
    assign phase_three_oe = drv[2];
    assign phase_four_oe = drv[3];

    // ==========================================================
    // power good, open drain
    logic pg_ok;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_good_flag_oe <= 1'b1;
            power_good_flag_out <= 1'b0;
        end else begin
            power_good_flag_oe <= !pg_ok;
            power_good_flag_out <= 1'b0;
        end
    end
    assign pg_ok = (state == mpps_pkg::ST_RUN) && !filt[mpps_pkg::SY_UV]
                   && !filt[mpps_pkg::SY_OV];

    // ==========================================================
    // axi4-lite slave
    logic aw_full;
    logic w_full;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_do;
    logic [31:0] status;
    logic [3:0] ar_addr;
    logic [15:0] aw_wide;
    logic [15:0] ar_wide;
    // widened so the upper-bit test stays legal when ADDR_W is 4
    assign aw_wide = 16'(s_axi_awaddr);
    assign ar_wide = 16'(s_axi_araddr);
    assign write_do = aw_full && w_full && !s_axi_bvalid;
    assign ar_addr = s_axi_araddr[3:0];
    assign status = {19'h00000, filt[mpps_pkg::SY_EN], drv & {pwm[3:2], pwm[1:0]},
                     pg_ok, nphase, state};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mpps_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= (|aw_wide[15:4]) ? 4'h3 : s_axi_awaddr[3:0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (write_do) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == mpps_pkg::ADDR_CTRL
                                || aw_addr == mpps_pkg::ADDR_PERIOD)
                               ? mpps_pkg::RESP_OKAY : mpps_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_run <= mpps_pkg::CTRL_RUN_RESET;
            period_reg <= mpps_pkg::PERIOD_RESET;
        end else if (write_do) begin
            if (aw_addr == mpps_pkg::ADDR_CTRL && w_strb[0]) begin
                ctrl_run <= w_data[mpps_pkg::CTRL_RUN_BIT];
            end
            if (aw_addr == mpps_pkg::ADDR_PERIOD) begin
                if (w_strb[0]) begin
                    period_reg[7:0] <= w_data[7:0];
                end
                if (w_strb[1]) begin
                    period_reg[PW-1:8] <= w_data[PW-1:8];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= mpps_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mpps_pkg::RESP_OKAY;
            if (|ar_wide[15:4]) begin
                s_axi_rdata <= '0;
                s_axi_rresp <= mpps_pkg::RESP_SLVERR;
            end else if (ar_addr == mpps_pkg::ADDR_CTRL) begin
                s_axi_rdata <= {31'h00000000, ctrl_run};
            end else if (ar_addr == mpps_pkg::ADDR_PERIOD) begin
                s_axi_rdata <= {23'h000000, period_reg};
            end else if (ar_addr == mpps_pkg::ADDR_STATUS) begin
                s_axi_rdata <= status;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= mpps_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // checks

    a_disable_off: assert property (!go |=> state == mpps_pkg::ST_OFF)
        else $error("not off after enable loss");
    a_idle_low: assert property (state == mpps_pkg::ST_OFF |=> pwm == 4'h0)
        else $error("phase high while off");
    a_unused_float: assert property (state == mpps_pkg::ST_RUN && !active[3]
        |-> !phase_four_oe)
        else $error("unused phase driven");
    a_strap_latch: assert property (state == mpps_pkg::ST_STRAP && strap_cnt == 4'h0
        && go |=> nphase == $past(next_nphase))
        else $error("phase count not latched from straps");
    a_count_hold: assert property (state != mpps_pkg::ST_STRAP |=> $stable(nphase))
        else $error("phase count changed outside sensing");
    a_quarter_gap: assert property (term[1] && nphase == mpps_pkg::NPH_FOUR |->
        ((PW+2)'(cyc) << 2) <= (PW+2)'(period_cur)
        && (((PW+2)'(cyc) + (PW+2)'(1)) << 2) > (PW+2)'(period_cur))
        else $error("second phase not a quarter after first");
    a_half_gap: assert property (term[1] && nphase == mpps_pkg::NPH_TWO |->
        ((PW+2)'(cyc) << 1) <= (PW+2)'(period_cur)
        && (((PW+2)'(cyc) + (PW+2)'(1)) << 1) > (PW+2)'(period_cur))
        else $error("second phase not half a cycle after first");
    a_pg_window: assert property (filt[mpps_pkg::SY_UV] || filt[mpps_pkg::SY_OV]
        |=> power_good_flag_oe)
        else $error("power good not pulled low");

    c_four: cover property (state == mpps_pkg::ST_RUN && nphase == mpps_pkg::NPH_FOUR);
    c_three: cover property (state == mpps_pkg::ST_RUN && nphase == mpps_pkg::NPH_THREE);
    c_two: cover property (state == mpps_pkg::ST_RUN && nphase == mpps_pkg::NPH_TWO);
    c_rise: cover property (state == mpps_pkg::ST_RUN ##1 $rose(pwm[0]));
endmodule

/* tb/mpps_drv_model.sv */
// Purpose: behavioural half-bridge driver behind one phase output
// Assumes: a high phase level commands the upper switch
// Notes: no dead time modelled; an undriven input counts as low
`timescale 1ns/1ps
module mpps_drv_model (
    input wire logic pwm,
    output logic upper_on,
    output logic lower_on
);
    // ==========================================================
    // switch pair
    // undriven or unknown input keeps the low side on, the safe state
    assign upper_on = pwm === 1'b1;
    assign lower_on = pwm !== 1'b1;
endmodule

/* tb/mpps_top_tb_top.sv */
// Purpose: self-checking bench for the multiphase pwm sequencer
// Assumes: soft-start shortened to 16 cycles; straps set during reset
// Notes: a monitor logs fall instants and counts rises of every phase pin
`timescale 1ns/1ps
module mpps_top_tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, ramp_cross, channel_current_sense_hold;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic supply_above_por, enable_above_threshold, freq_set_disable_pin, output_under_window;
    logic output_over_window, phase_one_out, phase_two_out, phase_three_in, phase_three_out;
    logic phase_three_oe, phase_four_in, phase_four_out, phase_four_oe, power_good_flag_out;
    logic power_good_flag_oe, soft_start_active, s3, s4;
    logic [3:0] ph, pv, up_on, lo_on;
    int num_errors, n_checks, cyc, fp, f[4], lowmin[4], nrise[4], nsmp[4], bsmp, nss;
    mpps_top #(.SS_CYCLES(16)) mpps_top_inst (.*);
    // ==========================================================
    // pins and drivers
    // a strapped pin is tied to the supply; an open one reads low
    assign phase_three_in = s3 | (phase_three_oe & phase_three_out);
    assign phase_four_in = s4 | (phase_four_oe & phase_four_out);
    assign ph = {phase_four_in, phase_three_in, phase_two_out, phase_one_out};
    mpps_drv_model mpps_drv_model_inst[3:0] (.pwm(ph), .upper_on(up_on), .lower_on(lo_on));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        pv <= ph;
        for (int k = 0; k < 4; k++) begin
            if (pv[k] && !ph[k]) f[k] <= cyc;
            if (!pv[k] && ph[k]) nrise[k] <= nrise[k] + 1;
            if (!pv[k] && ph[k] && cyc - f[k] < lowmin[k]) lowmin[k] <= cyc - f[k];
            if (channel_current_sense_hold[k]) nsmp[k] <= nsmp[k] + 1;
            if (channel_current_sense_hold[k] && ph[k]) bsmp <= bsmp + 1;
        end
        if (pv[0] && !ph[0]) fp <= f[0];
        if (soft_start_active) nss <= nss + 1;
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_ge(input int got, input int lim);
        n_checks++;
        if (got < lim) begin
            num_errors++;
            $display("BAD %0t %0d below %0d", $time, got, lim);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tmo(input int i);
        if (i >= 60) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            give_verdict();
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        tmo(i);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        tmo(i);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic boot(input logic a, input logic b);
        @(posedge aclk);
        s3 <= a;
        s4 <= b;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic wait_run;
        logic [31:0] d;
        logic [1:0] r;
        int i;
        for (i = 0; i < 60 && d[3:0] !== 4'h8; i++) axi_rd(4'h8, d, r);
        chk(d[3:0], 4'h8);
        if (d[3:0] !== 4'h8) tmo(i);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        boot(1'b0, 1'b0);
        @(posedge aclk);
        #1 chk({phase_one_out, phase_two_out, phase_three_oe, phase_four_oe,
            power_good_flag_oe, soft_start_active}, 6'h02);
        axi_rd(4'h0, d, r);
        chk(d[0], 1'b1);
        axi_rd(4'h4, d, r);
        chk(d[8:0], 9'h064);
        axi_wr(4'h8, 32'h0, r);
        chk(r, 2'h2);
        axi_wr(4'hC, 32'h0, r);
        chk(r, 2'h2);
        axi_rd(4'hC, d, r);
        chk({d, r}, {32'h0, 2'h2});
        $display("test reset done");
    endtask
    task automatic t_phase(input logic a, input logic b, input int n, input int p);
        logic [31:0] d;
        logic [1:0] r;
        int ss0;
        boot(a, b);
        ss0 = nss;
        axi_wr(4'h4, p, r);
        chk(r, 2'h0);
        wait_run();
        chk(nss - ss0, 16);
        lowmin = '{default: 9999};
        nrise = '{default: 0};
        nsmp = '{default: 0};
        repeat (4 * p) @(posedge aclk);
        axi_rd(4'h8, d, r);
        chk(d[6:4], n);
        chk(f[0] - fp, p);
        for (int k = 1; k < n; k++) chk((f[k] - f[0] + 4 * p) % p, k * p / n);
        for (int k = 0; k < n; k++) chk_ge(lowmin[k], (p + 3) / 4);
        for (int k = 0; k < n; k++) chk_ge(nrise[k], 2);
        for (int k = 0; k < n; k++) chk_ge(nsmp[k], 2);
        for (int k = n; k < 4; k++) chk(nsmp[k], 0);
        chk(bsmp, 0);
        chk({phase_three_oe, phase_four_oe}, {n > 2, n > 3});
        chk(up_on ^ lo_on, 4'hF);
        $display("test phases %0d period %0d done", n, p);
    endtask
    task automatic t_ramp;
        ramp_cross <= 4'h0;
        repeat (200) @(posedge aclk);
        nrise = '{default: 0};
        repeat (200) @(posedge aclk);
        chk(nrise[0] + nrise[1] + nrise[2] + nrise[3], 0);
        chk(ph, 4'h0);
        ramp_cross <= 4'hF;
        $display("test ramp done");
    endtask
    task automatic t_gate;
        for (int g = 0; g < 3; g++) begin
            supply_above_por <= g != 0;
            enable_above_threshold <= g != 1;
            freq_set_disable_pin <= g == 2;
            repeat (20) @(posedge aclk);
            chk({phase_one_out, phase_two_out, phase_three_oe, phase_four_oe,
                power_good_flag_oe}, 5'h01);
            supply_above_por <= 1'b1;
            enable_above_threshold <= 1'b1;
            freq_set_disable_pin <= 1'b0;
            wait_run();
        end
        chk(power_good_flag_oe, 1'b0);
        output_under_window <= 1'b1;
        repeat (10) @(posedge aclk);
        chk(power_good_flag_oe, 1'b1);
        output_under_window <= 1'b0;
        output_over_window <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({power_good_flag_oe, power_good_flag_out}, 2'h2);
        output_over_window <= 1'b0;
        $display("test gating done");
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'hF;
        {supply_above_por, enable_above_threshold, ramp_cross} = 6'h3F;
        {freq_set_disable_pin, output_under_window, output_over_window, s3, s4} = '0;
        t_reset();
        t_phase(1'b0, 1'b0, 4, 100);
        t_ramp();
        t_gate();
        t_phase(1'b0, 1'b0, 4, 25);
        // fourth pin tied high as well; it is ignored once the third is strapped
        t_phase(1'b1, 1'b1, 2, 100);
        t_phase(1'b0, 1'b1, 3, 100);
        give_verdict();
    end
endmodule
